// ==== design/sec_pkg.sv ====
// constants, command codes and state type for the serial eeprom controller
package sec_pkg;

	// ==========================================================
	// clock and link timing
	localparam int CLK_KHZ     = 100000;   // hclk rate
	localparam int SK_HALF_NS  = 250;      // least half period of link clock
	localparam int SK_HALF_CYC = (SK_HALF_NS * CLK_KHZ + 999999) / 1000000;
	localparam int TO_MS       = 30;       // eeprom response limit
	localparam int TO_CYC      = TO_MS * CLK_KHZ;

	// ==========================================================
	// register byte offsets (low address byte decoded)
	localparam logic [7:0] EEPROM_COMMAND_REG_OFS = 8'h00;
	localparam logic [7:0] EEPROM_DATA_REG_OFS    = 8'h04;
	localparam logic [7:0] EEPROM_CTRL_REG_OFS    = 8'h08;

	// ==========================================================
	// field positions
	localparam int PENDING_BIT  = 31;      // operation_pending_bit
	localparam int CODE_LSB     = 28;      // command_code_field [30:28]
	localparam int LOADED_BIT   = 10;      // data loaded status
	localparam int NORESP_BIT   = 9;       // no_response_flag
	localparam int SWRST_BIT    = 0;       // software_reset in ctrl reg
	localparam int LOAD_DONE_BIT = 1;      // ctrl reg: auto load finished

	// ==========================================================
	// command_code_field encodings
	localparam logic [2:0] CMD_FETCH     = 3'h0;
	localparam logic [2:0] CMD_LOCK      = 3'h1;
	localparam logic [2:0] CMD_UNLOCK    = 3'h2;
	localparam logic [2:0] CMD_STORE     = 3'h3;
	localparam logic [2:0] CMD_STORE_ALL = 3'h4;
	localparam logic [2:0] CMD_CLEAR     = 3'h5;
	localparam logic [2:0] CMD_CLEAR_ALL = 3'h6;
	localparam logic [2:0] CMD_REFETCH   = 3'h7;

	// ==========================================================
	// link framing: start bit, 2-bit opcode, 7-bit location, 8 data
	localparam logic [1:0] OP_EXT      = 2'h0;
	localparam logic [1:0] OP_WRITE    = 2'h1;
	localparam logic [1:0] OP_READ     = 2'h2;
	localparam logic [1:0] OP_ERASE    = 2'h3;
	localparam logic [6:0] EXT_LOCK    = 7'h00;
	localparam logic [6:0] EXT_STORE   = 7'h20;
	localparam logic [6:0] EXT_CLEAR   = 7'h40;
	localparam logic [6:0] EXT_UNLOCK  = 7'h60;
	localparam logic [4:0] BITS_SHORT  = 5'h0A;
	localparam logic [4:0] BITS_LONG   = 5'h12;

	// ==========================================================
	// image layout and defaults
	localparam logic [7:0]  SIG_VALUE  = 8'hA5;
	localparam int          SRAM_DEPTH = 512;
	localparam logic [6:0]  LOC_LAST   = 7'h7F;
	localparam logic [6:0]  LOC_MAC_LAST = 7'h06;
	localparam logic [6:0]  LOC_FS     = 7'h07;
	localparam logic [6:0]  LOC_HS     = 7'h08;
	localparam logic [6:0]  LOC_CFG    = 7'h09;
	localparam logic [6:0]  LOC_PWR    = 7'h7F;
	localparam logic [47:0] DEF_MAC    = 48'hFFFF_FFFF_FFFF;
	localparam logic [7:0]  DEF_FS     = 8'h01;
	localparam logic [7:0]  DEF_HS     = 8'h04;
	localparam logic [7:0]  DEF_CFG    = 8'h04;
	localparam logic [7:0]  DEF_PWR    = 8'hFA;
	localparam int          CFG_WAKE_BIT = 2;

	// ==========================================================
	// link sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_GAP,
		ST_POLL
	} sec_state_t;

endpackage

// ==== design/sec_top.sv ====
// serial eeprom controller: auto load, image sram, host commands
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps

// Overview of operation
// RULE1 - byte 0 must equal A5 for valid image
// RULE2 - no image: apply fixed default field values
// RULE3 - remote wake strap shapes default config flags
// RULE4 - auto load after every listed reset kind
// RULE5 - usb bus reset reloads only mac address
// RULE6 - signature good: copy image into 512-byte sram
// RULE7 - usb control block reads sram on demand
// RULE8 - bad signature ends init, registers keep defaults
// RULE9 - phy held disconnected until load completes
// RULE10 - host issues commands only after auto load
// RULE11 - host loads data before store commands
// RULE12 - pending bit set starts, cleared on completion
// RULE13 - fetch result lands in data register first
// RULE14 - host leaves command register alone while pending
// RULE15 - host unlocks modify before any erase/write
// RULE16 - no response in 30 ms sets flag
// RULE17 - clear single erases the addressed location
// RULE18 - clear every bulk-erases the whole eeprom
// RULE19 - lock/unlock modify framed to the eeprom
// RULE20 - store single/every write data register value
// RULE21 - 10 clocks short ops, 18 long ops
// RULE22 - refetch repeats checked load, sets loaded flag
// RULE23 - host prefers software reset over refetch
// RULE24 - three-wire link with start/opcode/address framing
// RULE25 - code encodings, field widths, offsets chosen here
module sec_top #(
	parameter int unsigned TIMEOUT_CYC = sec_pkg::TO_CYC
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// reset sources and strap
	input  wire logic        usb_bus_reset,
	input  wire logic        external_reset_pin_n,
	input  wire logic        remote_wake_strap,
	// usb control block side
	input  wire logic        sram_rd,
	input  wire logic [8:0]  sram_addr,
	output logic      [7:0]  sram_rdata,
	output logic             usb_phy_disconnect,
	output logic      [47:0] mac_addr,
	output logic      [7:0]  fs_poll_interval,
	output logic      [7:0]  hs_poll_interval,
	output logic      [7:0]  config_flags,
	output logic      [7:0]  max_power,
	// eeprom link
	output logic             eeprom_cs,
	output logic             serial_memory_clock,
	output logic             eeprom_do,
	input  wire logic        eeprom_di
);
	import sec_pkg::*;

	// ==========================================================
	// input synchronisers
	logic [2:0] sync1_q;      // first stage: data in, pin, strap
	logic [2:0] sync2_q;      // second stage, safe to read
	logic       pin_d_q;      // delayed pin for edge detect
	logic       di_s;
	logic       pin_s;
	logic       strap_s;

	// all three come from outside hclk; only stage two is looked at
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= 3'h2;
			sync2_q <= 3'h2;
			pin_d_q <= 1'b1;
		end else begin
			sync1_q <= {remote_wake_strap, external_reset_pin_n, eeprom_di};
			sync2_q <= sync1_q;
			pin_d_q <= sync2_q[1];
		end
	end
	assign di_s    = sync2_q[0];
	assign pin_s   = sync2_q[1];
	assign strap_s = sync2_q[2];

	// ==========================================================
	// bus slave state
	logic        ap_q;        // data phase in progress
	logic        wr_q;        // captured hwrite
	logic [7:0]  reg_q;       // captured register offset
	logic        bus_wr;
	logic [31:0] rd_mux;

	// host command state
	logic        operation_pending_bit_q;
	logic [2:0]  command_code_field_q;
	logic [6:0]  target_location_field_q;
	logic [7:0]  eeprom_data_reg_q;
	logic        no_response_flag_q;
	logic        loaded_q;

	// load request state
	logic        ld_req_q;    // a load is waiting
	logic        ld_full_req_q; // waiting load is a full one
	logic        trig_full;
	logic        take_load;

	// link sequencer state
	sec_state_t  st_q;
	logic [4:0]  div_q;       // half period divider
	logic        tick;
	logic [17:0] tx_q;        // frame, msb first
	logic [4:0]  bits_q;      // bits still to send
	logic [7:0]  rx_q;        // sampled return bits
	logic        poll_q;      // op needs a ready wait
	logic [21:0] to_cnt_q;    // ready wait counter
	logic        op_host_q;   // host op (not a load) running
	logic        ld_act_q;    // load running
	logic        ld_full_q;   // whole image, else mac only
	logic        ld_host_q;   // load was a refetch command
	logic [6:0]  ld_loc_q;    // location being loaded
	logic        hdone_q;     // host op finished (pulse)
	logic        hto_q;       // it ended by timeout
	logic        hok_q;       // refetch succeeded
	logic        to_last;
	logic        fin;
	logic        fin_to;
	logic        ld_ev;
	logic        sig_bad;
	logic        ld_end;
	logic [19:0] fr_host;     // {poll, long, frame}
	logic [19:0] fr_load;
	logic [6:0]  ld_nxt;

	// image memory
	logic [7:0]  mem [SRAM_DEPTH];

	// ==========================================================
	// frame builder: start bit, opcode, location, data
	function automatic logic [19:0] frame_f(input logic [2:0] c,
			input logic [6:0] a, input logic [7:0] d);
		logic [1:0] op;
		logic [6:0] ad;
		logic       lng;
		logic       pl;
		op  = OP_EXT;
		ad  = a;
		lng = 1'b0;
		pl  = 1'b0;
		unique case (c)
			CMD_FETCH, CMD_REFETCH: begin
				op  = OP_READ;
				lng = 1'b1;
			end
			CMD_STORE: begin  // RULE20
				op  = OP_WRITE;
				lng = 1'b1;
				pl  = 1'b1;
			end
			CMD_STORE_ALL: begin  // RULE20
				ad  = EXT_STORE;
				lng = 1'b1;
				pl  = 1'b1;
			end
			CMD_CLEAR: begin  // RULE17
				op  = OP_ERASE;
				pl  = 1'b1;
			end
			CMD_CLEAR_ALL: begin  // RULE18
				ad  = EXT_CLEAR;
				pl  = 1'b1;
			end
			CMD_LOCK:   ad = EXT_LOCK;  // RULE19
			CMD_UNLOCK: ad = EXT_UNLOCK;  // RULE19
		endcase
		// short frames use the top ten bits only
		return {pl, lng, 1'b1, op, ad, (lng ? d : 8'h00)};  // RULE24
	endfunction

	assign ld_nxt  = ld_act_q ? (ld_loc_q + 7'h01) : 7'h00;
	assign fr_host = frame_f(command_code_field_q, target_location_field_q,
		eeprom_data_reg_q);
	assign fr_load = frame_f(CMD_FETCH, ld_nxt, 8'h00);

	// ==========================================================
	// sequencer events
	assign tick    = (div_q == 5'(SK_HALF_CYC - 1));
	assign to_last = (to_cnt_q == 22'(TIMEOUT_CYC - 1));
	assign fin_to  = (st_q == ST_POLL) && !di_s && to_last;  // RULE16
	assign fin     = ((st_q == ST_GAP) && tick && !poll_q) ||
		((st_q == ST_POLL) && to_cnt_q > 22'h3 && (di_s || to_last));
	assign ld_ev   = fin && ld_act_q;
	assign sig_bad = (ld_loc_q == 7'h00) && (rx_q != SIG_VALUE);  // RULE1
	assign ld_end  = sig_bad ||
		(ld_loc_q == (ld_full_q ? LOC_LAST : LOC_MAC_LAST));
	assign take_load = (st_q == ST_IDLE) && ld_req_q;

	// link clock divider, free running; ticks pace every link edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= 5'h00;
		end else if (tick) begin
			div_q <= 5'h00;
		end else begin
			div_q <= div_q + 5'h01;
		end
	end

	// ==========================================================
	// link sequencer: frames, ready wait, load walk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q      <= ST_IDLE;
			eeprom_cs <= 1'b0;
			serial_memory_clock <= 1'b0;
			eeprom_do <= 1'b0;
			tx_q      <= 18'h0_0000;
			bits_q    <= 5'h00;
			rx_q      <= 8'h00;
			poll_q    <= 1'b0;
			to_cnt_q  <= 22'h00_0000;
			op_host_q <= 1'b0;
			ld_act_q  <= 1'b0;
			ld_full_q <= 1'b0;
			ld_host_q <= 1'b0;
			ld_loc_q  <= 7'h00;
			hdone_q   <= 1'b0;
			hto_q     <= 1'b0;
			hok_q     <= 1'b0;
		end else begin
			hdone_q <= 1'b0;
			hto_q   <= 1'b0;
			hok_q   <= 1'b0;
			unique case (st_q)
				ST_IDLE: begin
					// pending loads beat host commands
					if (ld_req_q) begin  // RULE4
						ld_act_q  <= 1'b1;
						ld_full_q <= ld_full_req_q;
						ld_host_q <= 1'b0;
						ld_loc_q  <= 7'h00;  // RULE6
						st_q      <= ST_SHIFT;
						eeprom_cs <= 1'b1;
						tx_q      <= fr_load[17:0];
						eeprom_do <= fr_load[17];
						bits_q    <= BITS_LONG;
						poll_q    <= 1'b0;
					end else if (operation_pending_bit_q && !hdone_q) begin
						// RULE12
						if (command_code_field_q == CMD_REFETCH) begin
							ld_act_q  <= 1'b1;  // RULE22
							ld_full_q <= 1'b1;
							ld_host_q <= 1'b1;
							ld_loc_q  <= 7'h00;
							tx_q      <= fr_load[17:0];
							eeprom_do <= fr_load[17];
							bits_q    <= BITS_LONG;
							poll_q    <= 1'b0;
						end else begin
							op_host_q <= 1'b1;
							tx_q      <= fr_host[17:0];
							eeprom_do <= fr_host[17];
							bits_q    <= fr_host[18] ? BITS_LONG : BITS_SHORT;
							poll_q    <= fr_host[19];  // RULE21
						end
						st_q      <= ST_SHIFT;
						eeprom_cs <= 1'b1;
					end
				end
				ST_SHIFT: begin
					// eeprom takes do on rising, we sample di on falling
					if (tick && !serial_memory_clock) begin
						serial_memory_clock <= 1'b1;
					end else if (tick) begin
						serial_memory_clock <= 1'b0;
						rx_q <= {rx_q[6:0], di_s};
						if (bits_q == 5'h01) begin  // RULE21
							eeprom_cs <= 1'b0;
							eeprom_do <= 1'b0;
							st_q      <= ST_GAP;
						end else begin
							tx_q      <= {tx_q[16:0], 1'b0};
							eeprom_do <= tx_q[16];
							bits_q    <= bits_q - 5'h01;
						end
					end
				end
				ST_GAP: begin
					// select low for one half period, then status check if poll_q is set
					if (tick && poll_q) begin
						eeprom_cs <= 1'b1;
						to_cnt_q  <= 22'h00_0000;
						st_q      <= ST_POLL;
					end
				end
				ST_POLL: begin
					// di high means the program cycle is over
					to_cnt_q <= to_cnt_q + 22'h00_0001;
				end
			endcase
			// end of one operation
			if (fin) begin
				eeprom_cs <= 1'b0;
				if (ld_act_q && !ld_end) begin
					// next byte of the image
					ld_loc_q  <= ld_nxt;
					st_q      <= ST_SHIFT;
					eeprom_cs <= 1'b1;
					tx_q      <= fr_load[17:0];
					eeprom_do <= fr_load[17];
					bits_q    <= BITS_LONG;
				end else if (ld_act_q) begin
					ld_act_q <= 1'b0;  // RULE8
					st_q     <= ST_IDLE;
					hdone_q  <= ld_host_q;
					hok_q    <= ld_host_q && !sig_bad;  // RULE22
				end else begin
					op_host_q <= 1'b0;
					st_q      <= ST_IDLE;
					hdone_q   <= 1'b1;  // RULE12
					hto_q     <= fin_to;  // RULE16
				end
			end
		end
	end

	// ==========================================================
	// load requests and phy disconnect
	assign trig_full = (pin_s && !pin_d_q) ||
		(bus_wr && (reg_q == EEPROM_CTRL_REG_OFS) && hwdata[SWRST_BIT]);

	// reset value asks for a full load, as a power-on does
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ld_req_q           <= 1'b1;  // RULE4
			ld_full_req_q      <= 1'b1;
			usb_phy_disconnect <= 1'b1;  // RULE9
		end else begin
			// a new trigger wins over the take
			if (trig_full || usb_bus_reset) begin
				ld_req_q <= 1'b1;  // RULE4
			end else if (take_load) begin
				ld_req_q <= 1'b0;
			end
			if (trig_full) begin
				ld_full_req_q <= 1'b1;
			end else if (take_load) begin
				ld_full_req_q <= 1'b0;  // RULE5
			end
			// bus reset and refetch keep the link up; reset-triggered full loads hold it off
			if (trig_full) begin
				usb_phy_disconnect <= 1'b1;  // RULE9
			end else if (ld_ev && ld_end && ld_full_q && !ld_host_q &&
					!ld_req_q) begin
				usb_phy_disconnect <= 1'b0;  // RULE9
			end
		end
	end

	// ==========================================================
	// loaded fields, written as image bytes arrive
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mac_addr         <= DEF_MAC;
			fs_poll_interval <= DEF_FS;
			hs_poll_interval <= DEF_HS;
			config_flags     <= DEF_CFG;
			max_power        <= DEF_PWR;
		end else if (ld_ev && sig_bad && !ld_host_q) begin
			mac_addr <= DEF_MAC;  // RULE2
			if (ld_full_q) begin
				fs_poll_interval <= DEF_FS;  // RULE2
				hs_poll_interval <= DEF_HS;
				config_flags     <= DEF_CFG;
				config_flags[CFG_WAKE_BIT] <= strap_s;  // RULE3
				max_power        <= DEF_PWR;
			end
		end else if (ld_ev && !sig_bad) begin
			// low mac byte is image byte 1
			for (int i = 0; i < 6; i++) begin
				if (ld_loc_q == 7'(i + 1)) begin
					mac_addr[8*i +: 8] <= rx_q;  // RULE5
				end
			end
			if (ld_full_q && ld_loc_q == LOC_FS) begin
				fs_poll_interval <= rx_q;
			end
			if (ld_full_q && ld_loc_q == LOC_HS) begin
				hs_poll_interval <= rx_q;
			end
			if (ld_full_q && ld_loc_q == LOC_CFG) begin
				config_flags <= rx_q;
			end
			if (ld_full_q && ld_loc_q == LOC_PWR) begin
				max_power <= rx_q;
			end
		end
	end

	// ==========================================================
	// image sram; mac-only loads refresh just their bytes
	always_ff @(posedge hclk) begin
		if (ld_ev && !sig_bad) begin
			mem[{2'b00, ld_loc_q}] <= rx_q;  // RULE6
		end
	end

	// read port for the usb control block, one cycle latency
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sram_rdata <= 8'h00;
		end else if (sram_rd) begin
			sram_rdata <= mem[sram_addr];  // RULE7
		end
	end

	// ==========================================================
	// host command and data registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			operation_pending_bit_q <= 1'b0;
			command_code_field_q    <= 3'h0;
			target_location_field_q <= 7'h00;
			eeprom_data_reg_q       <= 8'h00;
			no_response_flag_q      <= 1'b0;
			loaded_q                <= 1'b0;
		end else begin
			// writes while pending are dropped, protecting the op
			if (bus_wr && reg_q == EEPROM_COMMAND_REG_OFS &&
					!operation_pending_bit_q) begin
				command_code_field_q    <= hwdata[CODE_LSB +: 3];
				target_location_field_q <= hwdata[6:0];
				if (hwdata[PENDING_BIT]) begin
					operation_pending_bit_q <= 1'b1;  // RULE12
					no_response_flag_q      <= 1'b0;
					if (hwdata[CODE_LSB +: 3] == CMD_REFETCH) begin
						loaded_q <= 1'b0;
					end
				end
			end
			if (bus_wr && reg_q == EEPROM_DATA_REG_OFS &&
					!operation_pending_bit_q) begin
				eeprom_data_reg_q <= hwdata[7:0];
			end
			// completion; data lands with the bit clearing
			if (hdone_q) begin
				operation_pending_bit_q <= 1'b0;  // RULE12
				if (hto_q) begin
					no_response_flag_q <= 1'b1;  // RULE16
				end
				if (hok_q) begin
					loaded_q <= 1'b1;  // RULE22
				end
				if (command_code_field_q == CMD_FETCH) begin
					eeprom_data_reg_q <= rx_q;  // RULE13
				end
			end
		end
	end

	// ==========================================================
	// ahb-lite slave, one wait state on every transfer
	assign bus_wr = ap_q && wr_q;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (reg_q)
			EEPROM_COMMAND_REG_OFS: begin
				rd_mux[PENDING_BIT]      = operation_pending_bit_q;
				rd_mux[CODE_LSB +: 3]    = command_code_field_q;
				rd_mux[LOADED_BIT]       = loaded_q;
				rd_mux[NORESP_BIT]       = no_response_flag_q;
				rd_mux[6:0]              = target_location_field_q;
			end
			EEPROM_DATA_REG_OFS: rd_mux[7:0] = eeprom_data_reg_q;
			EEPROM_CTRL_REG_OFS: rd_mux[LOAD_DONE_BIT] = !ld_req_q && !ld_act_q;
			default: rd_mux = 32'h0000_0000;  // unmapped reads zero
		endcase
	end

	// wait state lets a read follow a write with fresh data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_q      <= 1'b0;
			wr_q      <= 1'b0;
			reg_q     <= 8'h00;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end else begin
			hresp <= 1'b0;  // always okay
			if (ap_q) begin
				ap_q      <= 1'b0;
				hreadyout <= 1'b1;
				hrdata    <= wr_q ? 32'h0000_0000 : rd_mux;
			end else if (hsel && hready && htrans[1]) begin
				ap_q      <= 1'b1;
				wr_q      <= hwrite;
				reg_q     <= haddr[7:0];  // RULE25
				hreadyout <= 1'b0;
			end
		end
	end

endmodule

// ==== testbench/sec_top_assertions.sv ====
// port checker for the serial eeprom controller
`timescale 1ns/10ps
module sec_top_checker #(
	parameter int unsigned TIMEOUT_CYC = 200
) (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// register bus
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// usb side and eeprom link
	input wire logic        usb_phy_disconnect,
	input wire logic        eeprom_cs,
	input wire logic        serial_memory_clock,
	input wire logic        eeprom_do
);
	logic [4:0]  rise_q;  // link clock rises this frame
	logic [31:0] cs_q;    // cycles with select high
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ==========================================================
	// frame counters, cleared whenever select is low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn || !eeprom_cs) begin
			rise_q <= 5'h00;
			cs_q   <= 32'h0;
		end else begin
			cs_q <= cs_q + 32'h1;
			if ($rose(serial_memory_clock))
				rise_q <= rise_q + 5'h01;
		end
	end

	// ==========================================================
	// assertions
	sequence s_data_phase;
		!hreadyout ##1 hreadyout;
	endsequence
	a_bus_two_cycle: assert property (hsel && hready && htrans[1]
		|=> s_data_phase) else $error("data phase length wrong");
	a_resp_okay: assert property (!hresp)
		else $error("error response seen");
	a_frame_clocks: assert property ($fell(eeprom_cs)
		|-> rise_q inside {5'h00, 5'h0A, 5'h12})
		else $error("wrong clock count in frame");
	a_start_bit_one: assert property ($rose(serial_memory_clock)
		&& rise_q == 5'h00 |-> eeprom_do) else $error("no start bit");
	a_clock_parked: assert property (!eeprom_cs |-> !serial_memory_clock)
		else $error("link clock runs outside frame");
	a_clock_high: assert property ($rose(serial_memory_clock)
		|-> serial_memory_clock[*8]) else $error("link clock high too short");
	a_phy_release: assert property ($fell(usb_phy_disconnect)
		|-> !eeprom_cs) else $error("phy released during load");
	a_load_start: assert property ($rose(hresetn)
		|-> ##[1:3] eeprom_cs) else $error("no load after reset");
	a_poll_bound: assert property (cs_q < TIMEOUT_CYC + 32'h3E8)
		else $error("operation not aborted in time");
endmodule

bind sec_top sec_top_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.usb_phy_disconnect(usb_phy_disconnect), .eeprom_cs(eeprom_cs),
	.serial_memory_clock(serial_memory_clock), .eeprom_do(eeprom_do));

// ==== testbench/sec_eeprom_model.sv ====
// behavioural three-wire serial eeprom for the controller bench
`timescale 1ns/10ps
module sec_eeprom_model import sec_pkg::*; (
	// link from controller
	input  wire logic hclk,
	input  wire logic cs,
	input  wire logic sk,
	input  wire logic din,
	// data back to controller
	output logic      dout
);
	logic [7:0]  mem_q [128];  // cell array
	logic [17:0] sh_q;         // bits seen this frame
	logic [4:0]  n_q;          // clock rises this frame
	logic [6:0]  a_q;          // location being read
	logic        rd_q, en_q, ok_q, sk_q;

	// erased cells, bytes 1..6 hold 11..16, modify locked at power up
	initial begin
		for (int i = 0; i < 128; i++)
			mem_q[i] = 8'hFF;
		for (int i = 1; i < 7; i++)
			mem_q[i] = 8'h10 + 8'(i);
		{n_q, rd_q, en_q, ok_q, sk_q, dout} = '0;
	end

	// shift on link clock rise, act when select drops
	always @(posedge hclk) begin : shift
		logic [1:0] op;
		logic [6:0] a;
		op = (n_q == 5'h12) ? sh_q[16:15] : sh_q[8:7];
		a = (n_q == 5'h12) ? sh_q[14:8] : sh_q[6:0];
		sk_q <= sk;
		if (!cs) begin
			dout <= ~dout;  // released line: no stale level
			n_q  <= 5'h00;
			if (n_q != 5'h00) begin
				ok_q <= en_q;  // locked ops never report ready
				case (op)
				OP_WRITE: if (en_q) mem_q[a] <= sh_q[7:0];
				OP_ERASE: if (en_q) mem_q[a] <= 8'hFF;
				OP_EXT: begin
					if (a == EXT_LOCK) en_q <= 1'b0;
					if (a == EXT_UNLOCK) en_q <= 1'b1;
					for (int i = 0; i < 128; i++) begin
						if (en_q && a == EXT_STORE) mem_q[i] <= sh_q[7:0];
						if (en_q && a == EXT_CLEAR) mem_q[i] <= 8'hFF;
					end
				end
				default: ;
				endcase
			end
		end else if (sk && !sk_q) begin
			n_q  <= n_q + 5'h01;
			sh_q <= {sh_q[16:0], din};
			if (n_q == 5'h0A) begin
				rd_q <= (op == OP_READ);
				a_q  <= a;
				dout <= mem_q[a][7];
			end else if (n_q > 5'h0A && rd_q)
				dout <= mem_q[a_q][5'h11 - n_q];
		end else if (n_q == 5'h00)
			dout <= ok_q;  // ready status while polled
	end
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the serial eeprom controller
`timescale 1ns/10ps
module testbench;
	import sec_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        bus_rst, pin_n, strap, sram_rd, cs, sk, e_do, e_di, disc;
	logic [8:0]  sram_addr;
	logic [7:0]  sram_rdata, fs, hs, cfg, pwr;
	logic [47:0] mac;
	int          mismatches, cmp_count;

	// ==========================================================
	// clock, design and eeprom
	always #5 hclk = ~hclk;
	sec_top #(.TIMEOUT_CYC(200)) dut_u (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .usb_bus_reset(bus_rst),
		.external_reset_pin_n(pin_n), .remote_wake_strap(strap),
		.sram_rd(sram_rd), .sram_addr(sram_addr), .sram_rdata(sram_rdata),
		.usb_phy_disconnect(disc), .mac_addr(mac), .fs_poll_interval(fs),
		.hs_poll_interval(hs), .config_flags(cfg), .max_power(pwr),
		.eeprom_cs(cs), .serial_memory_clock(sk), .eeprom_do(e_do),
		.eeprom_di(e_di));
	sec_eeprom_model mem_u (.hclk(hclk), .cs(cs), .sk(sk), .din(e_do),
		.dout(e_di));

	// ==========================================================
	// tasks
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one transfer; read data lands in r
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic cmd(input logic [2:0] c, input logic [6:0] loc);
		bus(1'b1, EEPROM_COMMAND_REG_OFS, {1'b1, c, 21'h000000, loc});
		bus(1'b0, EEPROM_COMMAND_REG_OFS, 32'h0);
		chk(r[PENDING_BIT], 1'b1);
		while (r[PENDING_BIT] !== 1'b0)
			bus(1'b0, EEPROM_COMMAND_REG_OFS, 32'h0);
	endtask
	task automatic fetch(input logic [6:0] loc, input logic [7:0] exp);
		cmd(CMD_FETCH, loc);
		bus(1'b0, EEPROM_DATA_REG_OFS, 32'h0);
		chk(r[7:0], exp);
	endtask
	// waits for auto load idle
	task automatic wait_load();
		repeat (8) @(posedge hclk);
		r = 32'h0;
		while (r[LOAD_DONE_BIT] !== 1'b1)
			bus(1'b0, EEPROM_CTRL_REG_OFS, 32'h0);
	endtask
	task automatic stop_test();
		$display("mismatches=%0d compares=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================================
	// watchdog, well past the run
	initial begin
		repeat (60000) @(posedge hclk);
		mismatches++;
		stop_test();
	end

	// ==========================================================
	// main sequence
	initial begin
		{hclk, hresetn, hsel, hwrite, bus_rst, strap, sram_rd} = '0;
		{haddr, hwdata, htrans, sram_addr} = '0;
		hsize = 3'h2;
		pin_n = 1'b1;
		{mismatches, cmp_count} = '0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(disc, 1'b1);
		wait_load();
		chk(disc, 1'b0);
		chk(mac, DEF_MAC);
		chk({fs, hs, pwr}, {DEF_FS, DEF_HS, DEF_PWR});
		chk(cfg, DEF_CFG & 8'hFB);
		cmd(CMD_UNLOCK, 7'h00);
		bus(1'b1, EEPROM_DATA_REG_OFS, 32'h000000A5);
		cmd(CMD_STORE, 7'h00);
		chk(r[NORESP_BIT], 1'b0);
		fetch(7'h00, SIG_VALUE);
		cmd(CMD_LOCK, 7'h00);
		cmd(CMD_STORE, 7'h01);
		chk(r[NORESP_BIT], 1'b1);
		fetch(7'h01, 8'h11);
		bus_rst <= 1'b1;
		@(posedge hclk);
		bus_rst <= 1'b0;
		wait_load();
		chk(mac, 48'h161514131211);
		chk(fs, DEF_FS);
		sram_addr <= 9'h001;
		sram_rd   <= 1'b1;
		@(posedge hclk);
		sram_rd <= 1'b0;
		@(posedge hclk);
		chk(sram_rdata, 8'h11);
		cmd(CMD_UNLOCK, 7'h00);
		cmd(CMD_CLEAR, 7'h02);
		fetch(7'h02, 8'hFF);
		fetch(7'h03, 8'h13);
		cmd(CMD_CLEAR_ALL, 7'h00);
		fetch(7'h04, 8'hFF);
		bus(1'b1, EEPROM_DATA_REG_OFS, 32'h0000005A);
		cmd(CMD_STORE_ALL, 7'h00);
		fetch(7'h7F, 8'h5A);
		cmd(CMD_REFETCH, 7'h00);
		chk(r[LOADED_BIT], 1'b0);
		pin_n <= 1'b0;
		repeat (5) @(posedge hclk);
		pin_n <= 1'b1;
		wait_load();
		chk(mac, DEF_MAC);
		bus(1'b1, EEPROM_CTRL_REG_OFS, 32'h00000001);
		repeat (3) @(posedge hclk);
		chk(disc, 1'b1);
		wait_load();
		chk(disc, 1'b0);
		stop_test();
	end
endmodule
